// File: hdl/zcd_pkg.sv
// Purpose: Constants for the zero-cross detector digital logic.
// Assumes: AXI4-Lite register access, 32-bit data, one clock.
// Notes: Functional notes below.
package zcd_pkg;
  localparam logic [3:0] ctrl_addr = 4'h0;
  localparam logic [3:0] status_addr = 4'h4;
  localparam logic [3:0] mask_addr = 4'h8;
  localparam int en_bit = 7;
  localparam int out_bit = 5;
  localparam int pol_bit = 4;
  localparam int rising_edge_irq_enable_bit = 1;
  localparam int falling_edge_irq_enable_bit = 0;
  localparam logic [7:0] ctrl_wmask = 8'h93;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam int sync_stages = 2;
  localparam logic [31:0] zero_word = 32'h0;
endpackage

// File: hdl/zcd_sync.sv
// Purpose: Two-stage level synchroniser for the comparator output.
// Assumes: Input may change at any time.
// Notes: First stage is read only by the second.
`timescale 1ns/1ps
module zcd_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic sync_out
);
  logic [zcd_pkg::sync_stages-1:0] stage;
  logic [zcd_pkg::sync_stages-1:0] next_stage;

  always_comb begin
    next_stage = {stage[zcd_pkg::sync_stages-2:0], async_in};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign sync_out = stage[zcd_pkg::sync_stages-1];
endmodule

// File: hdl/zcd_top.sv
// Purpose: Zero-cross detector control, edge interrupt and AXI4-Lite slave.
// Assumes: Comparator reports current sink as one; fuse is static after reset.
// Notes: Offsets 0x0 control, 0x4 status (write one to clear), 0x8 mask.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module zcd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sink_active,
  input wire logic default_off_fuse,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic detector_enable_out,
  output logic irq
);
  logic sink_sync;
  logic init_done, next_init_done;
  logic detector_enable, next_detector_enable;
  logic polarity_invert, next_polarity_invert;
  logic rising_edge_irq_enable, next_rising_edge_irq_enable;
  logic falling_edge_irq_enable, next_falling_edge_irq_enable;
  logic logic_out, next_logic_out;
  logic detector_irq_flag, next_detector_irq_flag;
  logic detector_irq_mask, next_detector_irq_mask;
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [3:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic w_strb0, next_w_strb0;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic aw_ready, next_aw_ready;
  logic w_ready, next_w_ready;
  logic ar_ready, next_ar_ready;
  logic next_irq;
  logic do_write, rise, fall, clr;
  logic [7:0] ctrl_view;

  // Synchroniser runs on every clock; no sleep gating, so drive and events continue in Sleep
  zcd_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(sink_active),
    .sync_out(sink_sync)
  );

  always_comb begin
    ctrl_view = '0;
    ctrl_view[zcd_pkg::en_bit] = detector_enable;
    ctrl_view[zcd_pkg::out_bit] = logic_out;
    ctrl_view[zcd_pkg::pol_bit] = polarity_invert;
    ctrl_view[zcd_pkg::rising_edge_irq_enable_bit] = rising_edge_irq_enable;
    ctrl_view[zcd_pkg::falling_edge_irq_enable_bit] = falling_edge_irq_enable;
  end

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb0 = w_strb0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_init_done = 1'b1;
    next_detector_enable = detector_enable;
    next_polarity_invert = polarity_invert;
    next_rising_edge_irq_enable = rising_edge_irq_enable;
    next_falling_edge_irq_enable = falling_edge_irq_enable;
    next_detector_irq_mask = detector_irq_mask;
    do_write = 1'b0;
    clr = 1'b0;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb0 = s_axi_wstrb[0];
    end
    if (aw_held && w_held && !bvalid) begin
      do_write = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = zcd_pkg::resp_okay;
      case (aw_addr)
        zcd_pkg::ctrl_addr: begin
          if (w_strb0) begin
            next_detector_enable = w_data[zcd_pkg::en_bit];
            next_polarity_invert = w_data[zcd_pkg::pol_bit];
            next_rising_edge_irq_enable = w_data[zcd_pkg::rising_edge_irq_enable_bit];
            next_falling_edge_irq_enable = w_data[zcd_pkg::falling_edge_irq_enable_bit];
          end
        end
        zcd_pkg::status_addr: begin
          clr = w_strb0 && w_data[0];
        end
        zcd_pkg::mask_addr: begin
          if (w_strb0) begin
            next_detector_irq_mask = w_data[0];
          end
        end
        default: begin
          next_bresp = zcd_pkg::resp_slverr;
        end
      endcase
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Fuse is sampled one edge after reset release, never under reset itself
    if (!init_done) begin
      next_detector_enable = !default_off_fuse;
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end else if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = zcd_pkg::resp_okay;
      case (s_axi_araddr)
        zcd_pkg::ctrl_addr: next_rdata = {24'h0, ctrl_view};
        zcd_pkg::status_addr: next_rdata = {31'h0, detector_irq_flag};
        zcd_pkg::mask_addr: next_rdata = {31'h0, detector_irq_mask};
        default: begin
          next_rdata = zcd_pkg::zero_word;
          next_rresp = zcd_pkg::resp_slverr;
        end
      endcase
    end
    // Readies leave flip-flops; aw and w mirror the inverse of their held flags, ar the inverse of rvalid
    next_aw_ready = !next_aw_held;
    next_w_ready = !next_w_held;
    next_ar_ready = !next_rvalid;
  end

  // Output follows the comparator and polarity even while disabled
  always_comb begin
    next_logic_out = sink_sync ^ polarity_invert;
    rise = next_logic_out && !logic_out && init_done;
    fall = !next_logic_out && logic_out && init_done;
    next_detector_irq_flag = detector_irq_flag;
    if (clr) begin
      next_detector_irq_flag = 1'b0;
    end
    // Set after clear so an edge in the clearing cycle survives
    if (rise && rising_edge_irq_enable) begin
      next_detector_irq_flag = 1'b1;
    end
    if (fall && falling_edge_irq_enable) begin
      next_detector_irq_flag = 1'b1;
    end
    next_irq = next_detector_irq_flag && next_detector_irq_mask;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_done <= 1'b0;
      detector_enable <= 1'b0;
      polarity_invert <= 1'b0;
      rising_edge_irq_enable <= 1'b0;
      falling_edge_irq_enable <= 1'b0;
      logic_out <= 1'b0;
      detector_irq_flag <= 1'b0;
      detector_irq_mask <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= zcd_pkg::resp_okay;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= zcd_pkg::resp_okay;
      irq <= 1'b0;
      aw_ready <= 1'b1;
      w_ready <= 1'b1;
      ar_ready <= 1'b1;
    end else begin
      init_done <= next_init_done;
      detector_enable <= next_detector_enable;
      polarity_invert <= next_polarity_invert;
      rising_edge_irq_enable <= next_rising_edge_irq_enable;
      falling_edge_irq_enable <= next_falling_edge_irq_enable;
      logic_out <= next_logic_out;
      detector_irq_flag <= next_detector_irq_flag;
      detector_irq_mask <= next_detector_irq_mask;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb0 <= next_w_strb0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      irq <= next_irq;
      aw_ready <= next_aw_ready;
      w_ready <= next_w_ready;
      ar_ready <= next_ar_ready;
    end
  end

  assign s_axi_awready = aw_ready;
  assign s_axi_wready = w_ready;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = ar_ready;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign detector_enable_out = detector_enable;

  a_fuse_default: assert property (@(posedge aclk) disable iff (!aresetn)
    !init_done |=> detector_enable == !$past(default_off_fuse))
    else $error("enable does not follow fuse after reset");
  a_fuse_hold_off: assert property (@(posedge aclk) disable iff (!aresetn)
    init_done && !detector_enable && !do_write |=> !detector_enable)
    else $error("enable set without a write");
  a_level_track: assert property (@(posedge aclk) disable iff (!aresetn)
    logic_out == ($past(sink_sync) ^ $past(polarity_invert)))
    else $error("level bit does not follow sink and polarity");
  a_rise_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    rise && rising_edge_irq_enable |=> detector_irq_flag)
    else $error("rising edge did not set flag");
  a_fall_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    fall && falling_edge_irq_enable |=> detector_irq_flag)
    else $error("falling edge did not set flag");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && $past(s_axi_araddr) == zcd_pkg::ctrl_addr && $rose(rvalid) |-> rdata[6] == 1'b0 && rdata[3:2] == 2'h0)
    else $error("reserved control bits read nonzero");
  a_pol_flip: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(polarity_invert) && $stable(sink_sync) |=> $changed(logic_out))
    else $error("polarity change did not flip level");
  a_clear_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    clr && ((rise && rising_edge_irq_enable) || (fall && falling_edge_irq_enable)) |=> detector_irq_flag)
    else $error("edge during clear was lost");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == (detector_irq_flag && detector_irq_mask))
    else $error("interrupt output mismatch");
endmodule

// File: test/zcd_ac_src.sv
// Purpose: AC source seen through the series resistor, as a sink/source level.
// Assumes: Level flips every half_cyc clocks while run is high.
// Notes: Holds its level while stopped, like a waveform parked near a peak.
`timescale 1ns/1ps
module zcd_ac_src #(
  parameter int half_cyc = 11
) (
  input wire logic aclk,
  input wire logic run,
  output logic sink_active
);
  int cnt = 0;
  initial sink_active = 1'b0;
  always @(posedge aclk) begin
    if (run) begin
      if (cnt == half_cyc - 1) begin
        cnt <= 0;
        sink_active <= !sink_active;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// File: test/testbench.sv
// Purpose: Self-checking bench for the zero-cross detector logic.
// Assumes: Results are read only after the AC source has parked and settled.
// Notes: Model flag follows every level change of sink xor polarity.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  localparam int half_cyc = 9;
  logic aclk = 0, aresetn = 0, fuse = 0, run = 0, sink_active;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
  logic [31:0] wdata = 0, rdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, en_out, irq;
  logic [1:0] bresp, rresp, r;
  logic m_en, m_pol = 0, m_ip = 0, m_in = 0, m_flag = 0, m_mask = 0, prev, cur, s0;
  int n_fail = 0, tests_run = 0, seed = 87;
  always #2.5 aclk = ~aclk;
  zcd_ac_src #(.half_cyc(half_cyc)) src (.aclk(aclk), .run(run), .sink_active(sink_active));
  zcd_top dut (.aclk(aclk), .aresetn(aresetn), .sink_active(sink_active), .default_off_fuse(fuse),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .detector_enable_out(en_out), .irq(irq));
  // Model of the logic output and the sticky flag
  always @(posedge aclk) begin
    cur = sink_active ^ m_pol;
    if (!aresetn) m_flag = 0;
    else if (cur != prev) m_flag = m_flag | (cur & m_ip) | (!cur & m_in);
    prev = cur;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    resp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    v = rdata; resp = rresp;
    rready <= 0;
  endtask
  task automatic set_ctrl(input logic [7:0] v);
    wr(zcd_pkg::ctrl_addr, {24'h0, v}, r);
    `CHK("bresp", zcd_pkg::resp_okay, r)
    {m_en, m_pol, m_ip, m_in} = {v[7], v[4], v[1], v[0]};
    repeat (6) @(posedge aclk);
  endtask
  task automatic chk_regs();
    rd(zcd_pkg::ctrl_addr, d, r);
    `CHK("rresp", zcd_pkg::resp_okay, r)
    `CHK("ctrl", {24'h0, m_en, 1'b0, sink_active ^ m_pol, m_pol, 2'b0, m_ip, m_in}, d)
    rd(zcd_pkg::status_addr, d, r);
    `CHK("status", {31'h0, m_flag}, d)
    `CHK("irq", m_flag & m_mask, irq)
  endtask
  task automatic do_reset(input logic f);
    aresetn <= 0; fuse <= f; m_pol = 0; m_ip = 0; m_in = 0; m_mask = 0; m_en = !f;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (4) @(posedge aclk);
  endtask
  task automatic test_done();
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    test_done();
  end
  initial begin
    do_reset(0);
    `CHK("en_out", 1'b1, en_out)
    chk_regs();
    set_ctrl(8'hff);
    chk_regs();
    for (int i = 0; i < 16; i++) begin
      set_ctrl({1'b1, 2'b0, i[2], 2'b0, i[1:0]});
      wr(zcd_pkg::status_addr, 32'h1, r);
      m_flag = 0;
      m_mask = i[3];
      wr(zcd_pkg::mask_addr, {31'h0, m_mask}, r);
      run <= 1;
      repeat (4 + ($random(seed) & 31)) @(posedge aclk);
      run <= 0;
      repeat (8) @(posedge aclk);
      chk_regs();
    end
    // Clear lands on the edge at which a source toggle sets the flag; the set must win
    for (int j = 0; j < 2; j++) begin
      set_ctrl({1'b1, 2'b0, j[0], 2'b0, 2'b11});
      run <= 1;
      s0 = sink_active;
      do @(posedge aclk); while (sink_active == s0);
      // Next toggle comes one half period on; three edges later it meets the clear's register edge
      repeat (half_cyc - 1) @(posedge aclk);
      wr(zcd_pkg::status_addr, 32'h1, r);
      run <= 0;
      repeat (8) @(posedge aclk);
      chk_regs();
    end
    wr(4'hc, $random(seed), r);
    `CHK("bad_wr", zcd_pkg::resp_slverr, r)
    rd(4'hc, d, r);
    `CHK("bad_rd", {zcd_pkg::resp_slverr, zcd_pkg::zero_word}, {r, d})
    do_reset(1);
    `CHK("en_off", 1'b0, en_out)
    set_ctrl(8'h13);
    chk_regs();
    set_ctrl(8'h80);
    `CHK("en_on", 1'b1, en_out)
    chk_regs();
    test_done();
  end
endmodule
